// [src/bsq_map.svh]
/*
  Constants of the battery/auxiliary port scan sequencer: timing figures,
  field positions and reset values.
  Assumes a 200 MHz system clock; included by the sample timer and the sequencer modules.
*/
// Operation
// - Wide-range battery input reaches the converter divided by four.
// - Narrow-range battery input reaches the converter divided by two.
// - Each battery divider is on only while its input is sampled.
// - Single reading: 2.625 us + reference delay + per sample (bits + 4.4 us).
// - Auxiliary inputs use the battery sequence, each into its own result.
// - Port scan skips touch screen channels, only non-touch inputs.
// - Port scan converts both battery and both auxiliary inputs in one run.
// - After a scan all four result registers hold the newest values.
// - One start command runs all four scan measurements without more commands.
// - Scan: 7.5 us + reference delay + 4 x averages x (bits + 4.4 us).
// - Contrast converter power follows its control setting.
// - Contrast converter sink is driven from an 8-bit loaded code.
// - Results are 16-bit words, 12-bit value right-aligned, top bits zero.
// - Contrast data takes bits 7..0 and ignores bits 15..8.
`ifndef BSQ_MAP_SVH
`define BSQ_MAP_SVH

`define BSQ_CLK_NS        5
`define BSQ_SINGLE_NS     2625
`define BSQ_SCAN_NS       7500
`define BSQ_ACQ_NS        4400
`define BSQ_CYC(ns)       (((ns) + `BSQ_CLK_NS - 1) / `BSQ_CLK_NS)
`define BSQ_SINGLE_CYC    `BSQ_CYC(`BSQ_SINGLE_NS)
`define BSQ_SCAN_CYC      `BSQ_CYC(`BSQ_SCAN_NS)
`define BSQ_ACQ_CYC       `BSQ_CYC(`BSQ_ACQ_NS)

`define BSQ_DIV_WIDE      4
`define BSQ_DIV_NARROW    2
`define BSQ_RESULT_MSB    11
`define BSQ_DAC_MSB       7
`define BSQ_RESULT_RST    16'h0000
`define BSQ_DAC_CODE_RST  8'h00
`define BSQ_DAC_PWR_RST   1'b0

`endif

// [src/bsq_pkg.sv]
/*
  Types of the port scan sequencer: states and channels.
  Assumes nothing beyond the constants header.
*/
package bsq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_CONV = 2'b10
  } bsq_state_e;

  typedef enum logic [1:0] {
    CH_BAT_WIDE   = 2'b00,
    CH_BAT_NARROW = 2'b01,
    CH_AUX_ONE    = 2'b10,
    CH_AUX_TWO    = 2'b11
  } bsq_chan_e;
endpackage

// [src/bsq_sample_timer.sv]
/*
  One sample: acquisition window of 4.4 us, then bits x conversion clock
  periods of conversion, then a one-cycle done pulse.
  Assumes go arrives only while the timer is idle.
*/
`include "bsq_map.svh"
module bsq_sample_timer import bsq_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       go,
  input  wire logic [3:0] nBits,
  input  wire logic [7:0] convDiv,
  output logic            acquire,
  output logic            done
);
  localparam logic [11:0] AcqCyc = 12'(`BSQ_ACQ_CYC);

  logic [11:0] cnt;
  logic        convPhase;
  logic [11:0] acqSpan;

  wire  [11:0] convSpan = {4'h0, convDiv} * {8'h00, nBits};
  // A zero divider would wrap the count to a 4096-cycle conversion; one cycle is the floor
  wire  [11:0] convLen  = (convSpan == 12'h000) ? 12'h001 : convSpan;
  wire         cntZero  = (cnt == 12'h000);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acquire   <= 1'b0;
      convPhase <= 1'b0;
      done      <= 1'b0;
      cnt       <= 12'h000;
    end else begin
      done <= convPhase & cntZero;
      if (go) begin
        acquire <= 1'b1;
        cnt     <= AcqCyc - 12'h001;
      end else if (acquire && cntZero) begin
        acquire   <= 1'b0;
        convPhase <= 1'b1;
        cnt       <= convLen - 12'h001;
      end else if (convPhase && cntZero) begin
        convPhase <= 1'b0;
      end else if (acquire || convPhase) begin
        cnt <= cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) acqSpan <= 12'h000;
    else        acqSpan <= acquire ? acqSpan + 12'h001 : 12'h000;
  end

  acq_window_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    $fell(acquire) |-> acqSpan == AcqCyc)
    else $error("acquisition window length wrong");

  done_pulse_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    done |=> !done)
    else $error("done lasts more than one cycle");
endmodule

// [src/bsq_sequencer.sv]
/*
  Battery/auxiliary measurement sequencer with port scan, plus the contrast
  D/A power and code holding.
  Assumes start strobes and DAC writes are one-cycle pulses synchronous to
  clk; the analog converter presents adcCode valid when a sample ends.
*/
`include "bsq_map.svh"
module bsq_sequencer import bsq_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        startSingle,
  input  wire logic [1:0]  singleChan,
  input  wire logic        startScan,
  input  wire logic [1:0]  resolution,
  input  wire logic [1:0]  averagingCount,
  input  wire logic [15:0] refDelay,
  input  wire logic [7:0]  convDiv,
  input  wire logic [11:0] adcCode,
  input  wire logic        dacPowerWr,
  input  wire logic        dacPowerSet,
  input  wire logic        dacDataWr,
  input  wire logic [15:0] dacDataIn,
  output logic             busy,
  output logic [1:0]       muxSel,
  output logic             sampleEn,
  output logic             divWideEn,
  output logic             divNarrowEn,
  output logic [15:0]      resultBatWide,
  output logic [15:0]      resultBatNarrow,
  output logic [15:0]      resultAuxOne,
  output logic [15:0]      resultAuxTwo,
  output logic [3:0]       resultUpdate,
  output logic             dacPowered,
  output logic [7:0]       dacCode
);
  localparam logic [16:0] SingleCyc = 17'(`BSQ_SINGLE_CYC);
  localparam logic [16:0] ScanCyc   = 17'(`BSQ_SCAN_CYC);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  bsq_state_e  state;
  bsq_chan_e   chan;
  logic        scanMode;
  logic [3:0]  sampleIdx;
  logic [15:0] accum;
  logic [16:0] leadCnt;
  logic        timerGo;
  logic        timerAcquire;
  logic        timerDone;
  logic [15:0] resultReg [4];

  wire        idle       = (state == ST_IDLE);
  wire        takeScan   = idle & startScan;
  wire        takeSingle = idle & startSingle & ~startScan;
  wire        take       = takeScan | takeSingle;
  wire [16:0] leadTarget = (startScan ? ScanCyc : SingleCyc)
                           + {1'b0, refDelay};
  wire [3:0]  avgLast    = (averagingCount == 2'h0) ? 4'h0 :
                           (averagingCount == 2'h1) ? 4'h3 :
                           (averagingCount == 2'h2) ? 4'h7 : 4'hf;
  wire [2:0]  avgShift   = (averagingCount == 2'h0) ? 3'h0 :
                           (averagingCount == 2'h1) ? 3'h2 :
                           (averagingCount == 2'h2) ? 3'h3 : 3'h4;
  wire [3:0]  nBits      = (resolution == 2'h1) ? 4'h8 :
                           (resolution == 2'h2) ? 4'ha : 4'hc;
  wire        lastSample = (sampleIdx == avgLast);
  wire        storeFire  = timerDone & lastSample;
  wire        moreChan   = scanMode & (chan != CH_AUX_TWO);
  wire        seqEnd     = storeFire & ~moreChan;
  wire [15:0] sumNext    = accum + {4'h0, adcCode};
  wire [15:0] avgWide    = sumNext >> avgShift;
  wire [15:0] avgWord    = {4'h0, avgWide[`BSQ_RESULT_MSB:0]};
  wire        leadDone   = (state == ST_LEAD) && (leadCnt == 17'h00000);
  wire        convNext   = timerDone & ~seqEnd;

  // ------------------------------------------------------------
  // Sequence control
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_IDLE;
      chan     <= CH_BAT_WIDE;
      scanMode <= 1'b0;
      leadCnt  <= 17'h00000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take) begin
            state    <= ST_LEAD;
            scanMode <= takeScan;
            chan     <= takeScan ? CH_BAT_WIDE : bsq_chan_e'(singleChan);
            leadCnt  <= leadTarget - 17'h00001;
          end
        end
        ST_LEAD: begin
          if (leadDone) state <= ST_CONV;
          else          leadCnt <= leadCnt - 17'h00001;
        end
        ST_CONV: begin
          if (seqEnd)        state <= ST_IDLE;
          else if (storeFire) chan <= bsq_chan_e'(chan + 2'h1);
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Averaging accumulator; restarts per channel
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accum     <= 16'h0000;
      sampleIdx <= 4'h0;
      timerGo   <= 1'b0;
    end else begin
      timerGo <= leadDone | convNext;
      if (storeFire || take) begin
        accum     <= 16'h0000;
        sampleIdx <= 4'h0;
      end else if (timerDone) begin
        accum     <= sumNext;
        sampleIdx <= sampleIdx + 4'h1;
      end
    end
  end

  bsq_sample_timer u_timer (
    .clk     (clk),
    .rst_b   (rst_b),
    .go      (timerGo),
    .nBits   (nBits),
    .convDiv (convDiv),
    .acquire (timerAcquire),
    .done    (timerDone)
  );

  // ------------------------------------------------------------
  // Analog steering
  // ------------------------------------------------------------
  // Dividers draw current, so they follow the acquisition window only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sampleEn    <= 1'b0;
      divWideEn   <= 1'b0;
      divNarrowEn <= 1'b0;
      busy        <= 1'b0;
    end else begin
      sampleEn    <= timerAcquire;
      divWideEn   <= timerAcquire & (chan == CH_BAT_WIDE);
      divNarrowEn <= timerAcquire & (chan == CH_BAT_NARROW);
      busy        <= take | (busy & ~seqEnd);
    end
  end
  assign muxSel = chan;

  // ------------------------------------------------------------
  // Result registers
  // ------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_res
    wire hit = storeFire && (chan == bsq_chan_e'(i));
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        resultReg[i]    <= `BSQ_RESULT_RST;
        resultUpdate[i] <= 1'b0;
      end else begin
        resultUpdate[i] <= hit;
        if (hit) resultReg[i] <= avgWord;
      end
    end
  end
  assign resultBatWide   = resultReg[0];
  assign resultBatNarrow = resultReg[1];
  assign resultAuxOne    = resultReg[2];
  assign resultAuxTwo    = resultReg[3];

  // ------------------------------------------------------------
  // Contrast converter
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dacPowered <= `BSQ_DAC_PWR_RST;
      dacCode    <= `BSQ_DAC_CODE_RST;
    end else begin
      if (dacPowerWr) dacPowered <= dacPowerSet;
      if (dacDataWr)  dacCode    <= dacDataIn[`BSQ_DAC_MSB:0];
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [16:0] leadSpan;
  logic [16:0] leadGoal;
  logic [3:0]  storedMask;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      leadSpan   <= 17'h00000;
      leadGoal   <= 17'h00000;
      storedMask <= 4'h0;
    end else begin
      leadSpan <= (state == ST_LEAD) ? leadSpan + 17'h00001 : 17'h00000;
      if (take) leadGoal <= leadTarget;
      if (take)            storedMask <= 4'h0;
      else if (storeFire)  storedMask <= storedMask | (4'h1 << chan);
    end
  end

  lead_time_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    leadDone |-> leadSpan == leadGoal - 17'h00001)
    else $error("lead time before sampling wrong");

  wide_divider_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    divWideEn |-> sampleEn && muxSel == CH_BAT_WIDE && !divNarrowEn)
    else $error("wide divider on outside its sample");

  narrow_divider_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    divNarrowEn |-> sampleEn && muxSel == CH_BAT_NARROW)
    else $error("narrow divider on outside its sample");

  divider_off_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    $fell(sampleEn) |-> !divWideEn && !divNarrowEn)
    else $error("divider left on after sampling");

  scan_all_four_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (seqEnd && scanMode) |=> storedMask == 4'hf && resultUpdate[3])
    else $error("scan did not store all four results");

  result_hold_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !$past(storeFire) |-> $stable(resultBatWide) && $stable(resultBatNarrow)
     && $stable(resultAuxOne) && $stable(resultAuxTwo))
    else $error("result changed without a finished conversion");

  result_upper_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (resultBatWide[15:12] | resultBatNarrow[15:12]
     | resultAuxOne[15:12] | resultAuxTwo[15:12]) == 4'h0)
    else $error("result upper bits not zero");

  dac_code_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    dacDataWr |=> dacCode == $past(dacDataIn[7:0]))
    else $error("contrast code not loaded from low byte");

  dac_power_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    dacPowerWr |=> dacPowered == $past(dacPowerSet))
    else $error("contrast power not following setting");

  scan_done_c: cover property (
    @(posedge clk) disable iff (!rst_b) seqEnd && scanMode);
  single_wide_c: cover property (
    @(posedge clk) disable iff (!rst_b) seqEnd && !scanMode && chan == 2'h0);
  averaged_c: cover property (
    @(posedge clk) disable iff (!rst_b) storeFire && sampleIdx == 4'hf);
  dac_load_c: cover property (
    @(posedge clk) disable iff (!rst_b) dacDataWr && dacPowered);
endmodule

// [tb/bsq_analog_front.sv]
/*
  Behavioural model of the analog front end behind the sequencer: input
  mux, the two battery dividers and a sample-and-hold converter.
  Assumes the sequencer reads adcCode at the end of each sample.
*/
module bsq_analog_front (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  muxSel,
  input  wire logic        sampleEn,
  input  wire logic        divWideEn,
  input  wire logic        divNarrowEn,
  input  wire logic [13:0] pinWide,
  input  wire logic [12:0] pinNarrow,
  input  wire logic [11:0] pinAuxOne,
  input  wire logic [11:0] pinAuxTwo,
  output logic      [11:0] adcCode
);
  timeunit 1ns;
  timeprecision 100ps;

  // Divider left off lets the raw pin through, so a miss gives a bad code
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adcCode <= 12'h000;
    end else if (sampleEn) begin
      case (muxSel)
        2'h0: adcCode <= divWideEn ? pinWide[13:2]
                                   : pinWide[11:0];
        2'h1: adcCode <= divNarrowEn ? pinNarrow[12:1]
                                     : pinNarrow[11:0];
        2'h2: adcCode <= pinAuxOne;
        default: adcCode <= pinAuxTwo;
      endcase
    end
  end
endmodule

// [tb/tb_battery_aux_port_scan_sequencer.sv]
/*
  Self-checking bench of the port scan sequencer with the analog front
  model. Assumes a 200 MHz clock and the sequencer's start/DAC strobes.
*/
module tb_battery_aux_port_scan_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 60000;
  localparam logic [13:0] PW = 14'h2468;
  localparam logic [12:0] PN = 13'h1357;
  localparam logic [11:0] PA = 12'h5a5;
  localparam logic [11:0] PB = 12'ha5a;
  logic        clk, rst_b, startSingle, startScan, dacPowerWr;
  logic        dacPowerSet, dacDataWr, busy, sampleEn, dacPowered;
  logic        divWideEn, divNarrowEn;
  logic [1:0]  singleChan, resolution, averagingCount, muxSel;
  logic [15:0] refDelay, dacDataIn, divBad, badChg;
  logic [7:0]  convDiv, dacCode;
  logic [11:0] adcCode;
  logic [15:0] resultBatWide, resultBatNarrow, resultAuxOne, resultAuxTwo;
  logic [15:0] prev [4];
  logic [3:0]  resultUpdate;
  logic [3:0]  upd [$];
  int          miscompares, nChecks, cyc;

  bsq_sequencer dut_u (.clk(clk), .rst_b(rst_b), .startSingle(startSingle),
    .singleChan(singleChan), .startScan(startScan), .resolution(resolution),
    .averagingCount(averagingCount), .refDelay(refDelay), .convDiv(convDiv),
    .adcCode(adcCode), .dacPowerWr(dacPowerWr), .dacPowerSet(dacPowerSet),
    .dacDataWr(dacDataWr), .dacDataIn(dacDataIn), .busy(busy),
    .muxSel(muxSel), .sampleEn(sampleEn), .divWideEn(divWideEn),
    .divNarrowEn(divNarrowEn), .resultBatWide(resultBatWide),
    .resultBatNarrow(resultBatNarrow), .resultAuxOne(resultAuxOne),
    .resultAuxTwo(resultAuxTwo), .resultUpdate(resultUpdate),
    .dacPowered(dacPowered), .dacCode(dacCode));

  bsq_analog_front front_u (.clk(clk), .rst_b(rst_b), .muxSel(muxSel),
    .sampleEn(sampleEn), .divWideEn(divWideEn), .divNarrowEn(divNarrowEn),
    .pinWide(PW), .pinNarrow(PN), .pinAuxOne(PA), .pinAuxTwo(PB),
    .adcCode(adcCode));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] res_of(input int i);
    case (i)
      0: return resultBatWide;
      1: return resultBatNarrow;
      2: return resultAuxOne;
      default: return resultAuxTwo;
    endcase
  endfunction

  function automatic logic [15:0] exp_of(input int i);
    case (i)
      0: return {4'h0, PW[13:2]};
      1: return {4'h0, PN[12:1]};
      2: return {4'h0, PA};
      default: return {4'h0, PB};
    endcase
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    nChecks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  // Duration is allowed a few cycles of slack around the formula
  task automatic chk_t(input string what, input int e, input int g);
    nChecks++;
    if (g < e - 3 || g > e + 3) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic go(input logic scan, input logic [1:0] ch);
    @(posedge clk);
    startScan <= scan;
    startSingle <= ~scan;
    singleChan <= ch;
    @(posedge clk);
    startScan <= 1'b0;
    startSingle <= 1'b0;
    #1;
  endtask

  task automatic measure(output int last);
    int n;
    n = 0;
    last = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
      if (resultUpdate !== 4'h0) last = n;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_single;
    int n, b;
    averagingCount <= 2'h0;
    convDiv <= 8'h01;
    for (int i = 0; i < 4; i++) begin
      resolution <= 2'(i);
      b = (i == 1) ? 8 : (i == 2) ? 10 : 12;
      upd.delete();
      go(1'b0, 2'(i));
      measure(n);
      // Let the falling-edge monitor log the update pulse first
      #2;
      chk_t("single time", 1 + 525 + 882 + b, n);
      chk("single result", exp_of(i), res_of(i));
      chk("single update", 16'(1 << i), {12'h0, upd[0]});
    end
  endtask

  // Sixteen-sample average, zero divider floored to a one-cycle conversion
  task automatic t_average;
    int n;
    resolution <= 2'h3;
    averagingCount <= 2'h3;
    convDiv <= 8'h00;
    refDelay <= 16'h0000;
    upd.delete();
    go(1'b0, 2'h1);
    measure(n);
    #2;
    chk_t("average time", 1 + 525 + 16 * (882 + 1), n);
    chk("average result", exp_of(1), resultBatNarrow);
    chk("average update", 16'h0002, {12'h0, upd[0]});
    chk("average count", 16'h0001, 16'(upd.size()));
  endtask

  task automatic t_scan;
    int n;
    resolution <= 2'h1;
    averagingCount <= 2'h1;
    convDiv <= 8'h02;
    refDelay <= 16'h000a;
    upd.delete();
    fork
      begin
        go(1'b1, 2'h2);
        measure(n);
      end
      begin
        repeat (300) @(posedge clk);
        startSingle <= 1'b1;
        @(posedge clk);
        startSingle <= 1'b0;
      end
    join
    chk_t("scan time", 1 + 1510 + 16 * (882 + 16), n);
    repeat (40) @(posedge clk);
    chk("scan updates", 16'h0004, 16'(upd.size()));
    for (int i = 0; i < 4; i++) begin
      chk("scan order", 16'(1 << i), {12'h0, upd[i]});
      chk("scan result", exp_of(i), res_of(i));
    end
    chk("divider misuse", 16'h0000, divBad);
    chk("stray change", 16'h0000, badChg);
  endtask

  task automatic t_dac;
    @(posedge clk);
    dacPowerWr <= 1'b1;
    dacPowerSet <= 1'b1;
    @(posedge clk);
    dacPowerWr <= 1'b0;
    dacDataWr <= 1'b1;
    dacDataIn <= 16'hab5c;
    @(posedge clk);
    dacDataWr <= 1'b0;
    #1;
    chk("dac power", 16'h0001, {15'h0, dacPowered});
    chk("dac code", 16'h005c, {8'h0, dacCode});
    @(posedge clk);
    dacPowerWr <= 1'b1;
    dacPowerSet <= 1'b0;
    dacDataWr <= 1'b1;
    dacDataIn <= 16'hff00;
    @(posedge clk);
    dacPowerWr <= 1'b0;
    dacDataWr <= 1'b0;
    #1;
    chk("dac power", 16'h0000, {15'h0, dacPowered});
    chk("dac code", 16'h0000, {8'h0, dacCode});
  endtask

  // ----------------------------------------------------------------
  // Monitors, clock, timeout and main sequence
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (resultUpdate !== 4'h0) upd.push_back(resultUpdate);
    if (divWideEn !== 1'b0 && !(sampleEn === 1'b1 && muxSel === 2'h0))
      divBad++;
    if (divNarrowEn !== 1'b0 && !(sampleEn === 1'b1 && muxSel === 2'h1))
      divBad++;
    for (int i = 0; i < 4; i++) begin
      if (res_of(i) !== prev[i] && resultUpdate[i] !== 1'b1) badChg++;
      prev[i] = res_of(i);
    end
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    {startSingle, startScan, dacPowerWr, dacPowerSet, dacDataWr} = 5'h00;
    {singleChan, resolution, averagingCount} = 6'h00;
    refDelay = 16'h0000;
    dacDataIn = 16'h0000;
    convDiv = 8'h01;
    {divBad, badChg} = 32'h0;
    for (int i = 0; i < 4; i++) prev[i] = 16'h0000;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("reset result", 16'h0000, resultBatWide | resultAuxTwo);
    chk("reset busy", 16'h0000, {15'h0, busy});
    t_average();
    t_single();
    t_scan();
    t_dac();
    close_out();
  end
endmodule
